// File: src/remote_xfer_cmd.sv
// remote memory transfer command interpreter with apb registers
//
// Behaviour
// - code 0x0201 writes local memory words into remote memory.
// - code 0x0202 reads remote memory words into local memory.
// - word count 1 to 256; exactly that many words move.
// - timeout field zero means default timeout of nine seconds.
// - timeout above 999 never expires; otherwise timeout in seconds.
// - connections 19201..19204 select auto-started managers on ports 0..3.
// - created connections carry their assigned number, 19221..19299.
// - write: fetch local words, build task-code messages, send on bound port.
// - write: check each response; failure sets error bit and code.
// - read: send requests, check responses, store words at local destination.
// - read errors set error bit and code in command error word.
// - write: offset 3 local source, offset 5 remote destination.
// - read: offset 3 remote source, offset 5 local destination.
// - accept only connections whose manager runs on its one port.
`timescale 1ns/1ps
module remote_xfer_cmd #(
  parameter longint SEC_CYCLES = xfer_pkg::SEC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [xfer_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [xfer_pkg::DATA_W-1:0] pwdata,
  output logic [xfer_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic lmem_req,
  output logic lmem_we,
  output logic [xfer_pkg::WORD_W-1:0] lmem_addr,
  output logic [xfer_pkg::WORD_W-1:0] lmem_wdata,
  input wire logic lmem_ack,
  input wire logic [xfer_pkg::WORD_W-1:0] lmem_rdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [xfer_pkg::WORD_W-1:0] tx_data,
  output logic [xfer_pkg::PORT_W-1:0] tx_port,
  output logic tx_last,
  input wire logic rx_valid,
  input wire logic [xfer_pkg::WORD_W-1:0] rx_code,
  input wire logic [xfer_pkg::WORD_W-1:0] rx_data
);
  import xfer_pkg::*;

  // ==========================================
  // apb slave
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic acc;
  logic wr_fire;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  logic [WORD_W-1:0] err_word_ff;
  logic [WORD_W-1:0] blk_ff [1:6];
  logic [NUM_PORTS-1:0] run_auto_ff;
  logic [NUM_PORTS-1:0] run_made_ff;
  logic [WORD_W-1:0] conn_num_ff [0:NUM_PORTS-1];
  logic done_ff;
  logic err_flag_ff;
  logic [WORD_W-1:0] progress_ff;
  seq_state_t state_ff;
  logic start;

  assign acc = psel & penable & ~pready_ff;
  assign wr_fire = psel & penable & pready_ff & pwrite;
  assign start = wr_fire && paddr == REG_CTRL && pwdata[CTRL_START_BIT];
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end else if (paddr < REG_CTRL) begin
      // reserved words 7..15 read as zero
      case (paddr[5:2])
        4'h0: rd_data[WORD_W-1:0] = err_word_ff;
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: rd_data[WORD_W-1:0] = blk_ff[paddr[5:2]];
        default: rd_data = '0;
      endcase
    end else if (paddr == REG_CTRL) begin
      rd_data = '0;
    end else if (paddr == REG_STATUS) begin
      rd_data[STAT_BUSY_BIT] = state_ff != S_IDLE;
      rd_data[STAT_DONE_BIT] = done_ff;
      rd_data[STAT_ERR_BIT] = err_flag_ff;
    end else if (paddr == REG_PORT_RUN) begin
      rd_data[RUN_AUTO_LSB +: NUM_PORTS] = run_auto_ff;
      rd_data[RUN_MADE_LSB +: NUM_PORTS] = run_made_ff;
    end else if (paddr >= REG_CONN_BASE && paddr < REG_PROGRESS) begin
      rd_data[WORD_W-1:0] = conn_num_ff[2'(paddr[3:2] - REG_CONN_BASE[3:2])];
    end else if (paddr == REG_PROGRESS) begin
      rd_data[WORD_W-1:0] = progress_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~rd_ok;
      prdata_ff <= (acc && !pwrite && rd_ok) ? rd_data : '0;
    end
  end

  // command block words 1..6 and connection table
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 1; i <= 6; i++) begin
        blk_ff[i] <= RESET_WORD;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        conn_num_ff[p] <= RESET_WORD;
      end
      run_auto_ff <= '0;
      run_made_ff <= '0;
    end else if (wr_fire && paddr[1:0] == 2'b00) begin
      if (paddr < REG_CTRL && paddr[5:2] >= 4'h1 && paddr[5:2] <= 4'h6) begin
        blk_ff[paddr[5:2]] <= pwdata[WORD_W-1:0];
      end else if (paddr == REG_PORT_RUN) begin
        run_auto_ff <= pwdata[RUN_AUTO_LSB +: NUM_PORTS];
        run_made_ff <= pwdata[RUN_MADE_LSB +: NUM_PORTS];
      end else if (paddr >= REG_CONN_BASE && paddr < REG_PROGRESS) begin
        conn_num_ff[2'(paddr[3:2] - REG_CONN_BASE[3:2])] <= pwdata[WORD_W-1:0];
      end
    end
  end

  // ==========================================
  // command capture and connection lookup
  logic is_write_ff;
  logic [WORD_W-1:0] loc_base_ff;
  logic [WORD_W-1:0] rem_base_ff;
  logic [WORD_W-1:0] count_ff;
  logic [PORT_W-1:0] port_ff;
  logic conn_hit;
  logic [PORT_W-1:0] conn_port;
  logic conn_range;
  logic [WORD_W-1:0] conn;

  assign conn = blk_ff[OFS_CONN];

  always_comb begin
    conn_hit = 1'b0;
    conn_port = '0;
    conn_range = 1'b1;
    if (conn >= CONN_AUTO_FIRST && conn <= CONN_AUTO_LAST) begin
      conn_port = PORT_W'(conn - CONN_AUTO_FIRST);
      conn_hit = run_auto_ff[conn_port];
    end else if (conn >= CONN_MADE_FIRST && conn <= CONN_MADE_LAST) begin
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
        if (run_made_ff[p] && conn_num_ff[p] == conn) begin
          conn_hit = 1'b1;
          conn_port = PORT_W'(p);
        end
      end
    end else begin
      conn_range = 1'b0;
    end
  end

  // ==========================================
  // timeout in whole seconds
  logic [SEC_CNT_W-1:0] sec_cnt_ff;
  logic [WORD_W-1:0] elapsed_ff;
  logic [WORD_W-1:0] limit_ff;
  logic tmo_inf_ff;
  logic tmo_fire;
  logic sec_tick;

  assign sec_tick = sec_cnt_ff == SEC_CNT_W'(SEC_CYCLES - 1);
  assign tmo_fire = state_ff != S_IDLE && state_ff != S_CHECK && !tmo_inf_ff &&
                    elapsed_ff >= limit_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sec_cnt_ff <= '0;
      elapsed_ff <= '0;
      limit_ff <= DEFAULT_TMO_S;
      tmo_inf_ff <= 1'b0;
    end else if (state_ff == S_IDLE) begin
      sec_cnt_ff <= '0;
      elapsed_ff <= '0;
      limit_ff <= (blk_ff[OFS_TMO] == '0) ? DEFAULT_TMO_S : blk_ff[OFS_TMO];
      tmo_inf_ff <= blk_ff[OFS_TMO] > TMO_INF_ABOVE;
    end else begin
      sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 1'b1;
      if (sec_tick && elapsed_ff != '1) begin
        elapsed_ff <= elapsed_ff + 1'b1;
      end
    end
  end

  // ==========================================
  // outgoing message buffer
  logic push_valid;
  logic push_ready;
  logic [WORD_W-1:0] push_word;
  logic push_last;
  logic [TX_W-1:0] tx_bus;

  word_skid_buf #(
    .W(TX_W)
  ) u_tx_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({push_last, port_ff, push_word}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_bus)
  );

  assign tx_last = tx_bus[TX_W-1];
  assign tx_port = tx_bus[WORD_W +: PORT_W];
  assign tx_data = tx_bus[WORD_W-1:0];

  // ==========================================
  // transfer sequencer
  logic [WORD_W-1:0] idx_ff;
  logic [WORD_W-1:0] data_ff;
  logic lmem_req_ff;
  logic lmem_we_ff;
  logic [WORD_W-1:0] lmem_addr_ff;
  logic [WORD_W-1:0] lmem_wdata_ff;
  logic fail_ff;
  logic [WORD_W-1:0] fail_code_ff;

  assign lmem_req = lmem_req_ff;
  assign lmem_we = lmem_we_ff;
  assign lmem_addr = lmem_addr_ff;
  assign lmem_wdata = lmem_wdata_ff;

  always_comb begin
    push_valid = 1'b0;
    push_word = '0;
    push_last = 1'b0;
    case (state_ff)
      S_SEND_TC: begin
        push_valid = 1'b1;
        push_word = is_write_ff ? TC_WRITE_WORD : TC_READ_WORD;
      end
      S_SEND_ADDR: begin
        push_valid = 1'b1;
        push_word = rem_base_ff + idx_ff;
        push_last = !is_write_ff;
      end
      S_SEND_DATA: begin
        push_valid = 1'b1;
        push_word = data_ff;
        push_last = 1'b1;
      end
      default: push_valid = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= S_IDLE;
      is_write_ff <= 1'b0;
      loc_base_ff <= '0;
      rem_base_ff <= '0;
      count_ff <= '0;
      port_ff <= '0;
      idx_ff <= '0;
      data_ff <= '0;
      lmem_req_ff <= 1'b0;
      lmem_we_ff <= 1'b0;
      lmem_addr_ff <= '0;
      lmem_wdata_ff <= '0;
      fail_ff <= 1'b0;
      fail_code_ff <= '0;
    end else begin
      fail_ff <= 1'b0;
      if (tmo_fire) begin
        lmem_req_ff <= 1'b0;
        fail_ff <= 1'b1;
        fail_code_ff <= ERR_TIMEOUT;
        state_ff <= S_IDLE;
      end else begin
        case (state_ff)
          S_IDLE: begin
            // a start while busy never reaches here
            if (start) begin
              is_write_ff <= blk_ff[OFS_CMD] == CMD_WRITE_REMOTE;
              // source and destination swap roles with direction
              loc_base_ff <= (blk_ff[OFS_CMD] == CMD_WRITE_REMOTE) ?
                             blk_ff[OFS_SRC] : blk_ff[OFS_DST];
              rem_base_ff <= (blk_ff[OFS_CMD] == CMD_WRITE_REMOTE) ?
                             blk_ff[OFS_DST] : blk_ff[OFS_SRC];
              count_ff <= blk_ff[OFS_CNT];
              idx_ff <= '0;
              state_ff <= S_CHECK;
            end
          end
          S_CHECK: begin
            state_ff <= S_IDLE;
            fail_ff <= 1'b1;
            if (blk_ff[OFS_CMD] != CMD_WRITE_REMOTE && blk_ff[OFS_CMD] != CMD_READ_REMOTE) begin
              fail_code_ff <= ERR_BAD_COMMAND;
            end else if (count_ff < MIN_WORDS || count_ff > MAX_WORDS) begin
              fail_code_ff <= ERR_BAD_COUNT;
            end else if (!conn_range) begin
              fail_code_ff <= ERR_BAD_CONN;
            end else if (!conn_hit) begin
              fail_code_ff <= ERR_PORT_IDLE;
            end else begin
              fail_ff <= 1'b0;
              port_ff <= conn_port;
              if (is_write_ff) begin
                lmem_req_ff <= 1'b1;
                lmem_we_ff <= 1'b0;
                lmem_addr_ff <= loc_base_ff;
                state_ff <= S_LREAD;
              end else begin
                state_ff <= S_SEND_TC;
              end
            end
          end
          S_LREAD: begin
            if (lmem_ack) begin
              lmem_req_ff <= 1'b0;
              data_ff <= lmem_rdata;
              state_ff <= S_SEND_TC;
            end
          end
          S_SEND_TC: begin
            if (push_ready) begin
              state_ff <= S_SEND_ADDR;
            end
          end
          S_SEND_ADDR: begin
            if (push_ready) begin
              state_ff <= is_write_ff ? S_SEND_DATA : S_WAIT_RSP;
            end
          end
          S_SEND_DATA: begin
            if (push_ready) begin
              state_ff <= S_WAIT_RSP;
            end
          end
          S_WAIT_RSP: begin
            if (rx_valid) begin
              if (rx_code != (is_write_ff ? TC_WRITE_WORD : TC_READ_WORD)) begin
                fail_ff <= 1'b1;
                fail_code_ff <= ERR_REMOTE_NAK;
                state_ff <= S_IDLE;
              end else if (is_write_ff) begin
                state_ff <= S_NEXT;
              end else begin
                lmem_req_ff <= 1'b1;
                lmem_we_ff <= 1'b1;
                lmem_addr_ff <= loc_base_ff + idx_ff;
                lmem_wdata_ff <= rx_data;
                state_ff <= S_LWRITE;
              end
            end
          end
          S_LWRITE: begin
            if (lmem_ack) begin
              lmem_req_ff <= 1'b0;
              state_ff <= S_NEXT;
            end
          end
          S_NEXT: begin
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff + 1'b1 == count_ff) begin
              state_ff <= S_IDLE;
            end else if (is_write_ff) begin
              lmem_req_ff <= 1'b1;
              lmem_we_ff <= 1'b0;
              lmem_addr_ff <= loc_base_ff + idx_ff + 1'b1;
              state_ff <= S_LREAD;
            end else begin
              state_ff <= S_SEND_TC;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // error word, status flags, progress
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_word_ff <= RESET_WORD;
    end else if (fail_ff) begin
      err_word_ff <= fail_code_ff;
    end else if (wr_fire && paddr == 8'h00) begin
      err_word_ff <= pwdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_ff <= 1'b0;
      err_flag_ff <= 1'b0;
      progress_ff <= '0;
    end else begin
      if (state_ff == S_IDLE && start) begin
        done_ff <= 1'b0;
        err_flag_ff <= 1'b0;
        progress_ff <= '0;
      end else begin
        if (fail_ff) begin
          err_flag_ff <= 1'b1;
          done_ff <= 1'b1;
        end
        if (state_ff == S_NEXT && !tmo_fire) begin
          progress_ff <= idx_ff + 1'b1;
          if (idx_ff + 1'b1 == count_ff) begin
            done_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// File: src/word_skid_buf.sv
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module word_skid_buf #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic out_valid_ff;
  logic [W-1:0] out_data_ff;
  logic skid_valid_ff;
  logic [W-1:0] skid_data_ff;
  logic take_in;
  logic out_free;

  assign in_ready = ~skid_valid_ff;
  assign take_in = in_valid & ~skid_valid_ff;
  assign out_free = ~out_valid_ff | out_ready;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (out_free) begin
      if (skid_valid_ff) begin
        out_valid_ff <= 1'b1;
        out_data_ff <= skid_data_ff;
      end else begin
        out_valid_ff <= take_in;
        out_data_ff <= in_data;
      end
    end
  end

  // second slot catches a word while the receiver stalls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      skid_valid_ff <= 1'b0;
      skid_data_ff <= '0;
    end else if (out_free) begin
      if (skid_valid_ff && take_in) begin
        skid_data_ff <= in_data;
      end else begin
        skid_valid_ff <= 1'b0;
      end
    end else if (take_in) begin
      skid_valid_ff <= 1'b1;
      skid_data_ff <= in_data;
    end
  end
endmodule

// File: src/xfer_pkg.sv
// constants, register map and state codes for the remote memory transfer block
package xfer_pkg;

  // ==========================================
  // widths
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 2;
  localparam int NUM_PORTS = 4;
  localparam int TX_W = WORD_W + PORT_W + 1;

  // ==========================================
  // command block word indices (byte address = index * 4)
  localparam int OFS_ERR = 0;
  localparam int OFS_CMD = 1;
  localparam int OFS_CONN = 2;
  localparam int OFS_SRC = 3;
  localparam int OFS_CNT = 4;
  localparam int OFS_DST = 5;
  localparam int OFS_TMO = 6;
  localparam int BLK_WORDS = 16;

  // ==========================================
  // extra registers
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h44;
  localparam logic [ADDR_W-1:0] REG_PORT_RUN = 8'h48;
  localparam logic [ADDR_W-1:0] REG_CONN_BASE = 8'h4C;
  localparam logic [ADDR_W-1:0] REG_PROGRESS = 8'h5C;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int RUN_AUTO_LSB = 0;
  localparam int RUN_MADE_LSB = 4;
  localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;

  // ==========================================
  // command codes and connection numbers
  localparam logic [WORD_W-1:0] CMD_WRITE_REMOTE = 16'h0201;
  localparam logic [WORD_W-1:0] CMD_READ_REMOTE = 16'h0202;
  localparam logic [WORD_W-1:0] CONN_AUTO_FIRST = 16'h4B01;
  localparam logic [WORD_W-1:0] CONN_AUTO_LAST = 16'h4B04;
  localparam logic [WORD_W-1:0] CONN_MADE_FIRST = 16'h4B15;
  localparam logic [WORD_W-1:0] CONN_MADE_LAST = 16'h4B63;
  localparam logic [WORD_W-1:0] MIN_WORDS = 16'h0001;
  localparam logic [WORD_W-1:0] MAX_WORDS = 16'h0100;

  // ==========================================
  // task codes carried on the serial link
  localparam logic [WORD_W-1:0] TC_WRITE_WORD = 16'h00A1;
  localparam logic [WORD_W-1:0] TC_READ_WORD = 16'h00A2;

  // ==========================================
  // error codes written to the command error word
  localparam logic [WORD_W-1:0] ERR_BAD_COMMAND = 16'h0001;
  localparam logic [WORD_W-1:0] ERR_BAD_COUNT = 16'h0002;
  localparam logic [WORD_W-1:0] ERR_BAD_CONN = 16'h0003;
  localparam logic [WORD_W-1:0] ERR_PORT_IDLE = 16'h0004;
  localparam logic [WORD_W-1:0] ERR_REMOTE_NAK = 16'h0005;
  localparam logic [WORD_W-1:0] ERR_TIMEOUT = 16'h0006;

  // ==========================================
  // timing
  localparam longint CLK_HZ = 50000000;
  localparam longint TICK_S = 1;
  localparam longint SEC_CYCLES = CLK_HZ * TICK_S;
  localparam logic [WORD_W-1:0] DEFAULT_TMO_S = 16'h0009;
  localparam logic [WORD_W-1:0] TMO_INF_ABOVE = 16'h03E7;
  localparam int SEC_CNT_W = 32;

  // ==========================================
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CHECK = 4'b0001,
    S_LREAD = 4'b0010,
    S_SEND_TC = 4'b0011,
    S_SEND_ADDR = 4'b0100,
    S_SEND_DATA = 4'b0101,
    S_WAIT_RSP = 4'b0110,
    S_LWRITE = 4'b0111,
    S_NEXT = 4'b1000
  } seq_state_t;

endpackage

// File: verification/remote_plc_model.sv
// remote controller on the task-code link
`timescale 1ns/1ps
module remote_plc_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] mode,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] tx_data,
  input wire logic [1:0] tx_port,
  input wire logic tx_last,
  output logic rx_valid,
  output logic [15:0] rx_code,
  output logic [15:0] rx_data
);
  // mode: 0 prompt, 1 refuses, 2 silent, 3 slow with stalls
  logic [15:0] rm [0:65535];
  logic [1:0] pos_ff, last_port;
  logic [15:0] code_ff, addr_ff;
  int wait_ff;
  initial begin
    for (int i = 0; i < 65536; i++) rm[i] = 16'(i) + 16'h1000;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_code = 16'h5A5A;
    rx_data = 16'hC3C3;
  end
  always @(posedge sys_clk) begin
    rx_valid <= 1'b0;
    rx_code <= ~rx_code;
    rx_data <= ~rx_data;
    tx_ready <= !tx_ready || mode != 2'h3;
    if (wait_ff != 0) wait_ff <= wait_ff - 1;
    if (reset) begin
      pos_ff <= 2'h0;
      wait_ff <= 0;
    end else begin
      if (tx_valid && tx_ready) begin
        pos_ff <= tx_last ? 2'h0 : pos_ff + 2'h1;
        if (pos_ff == 2'h0) code_ff <= tx_data;
        if (pos_ff == 2'h0) last_port <= tx_port;
        if (pos_ff == 2'h1) addr_ff <= tx_data;
        if (pos_ff == 2'h2 && mode != 2'h1) rm[addr_ff] <= tx_data;
        if (tx_last && mode != 2'h2) wait_ff <= mode == 2'h3 ? 20 : 1;
      end
      if (wait_ff == 1) begin
        rx_valid <= 1'b1;
        rx_code <= mode == 2'h1 ? ~code_ff : code_ff;
        rx_data <= rm[addr_ff];
      end
    end
  end
endmodule

// File: verification/remote_xfer_cmd_asserts.sv
// port-level assertions for the remote transfer block
`timescale 1ns/1ps
module remote_xfer_cmd_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [xfer_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lmem_req,
  input wire logic lmem_we,
  input wire logic lmem_ack,
  input wire logic [xfer_pkg::WORD_W-1:0] lmem_addr,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [xfer_pkg::WORD_W-1:0] tx_data,
  input wire logic [xfer_pkg::PORT_W-1:0] tx_port,
  input wire logic tx_last
);
  import xfer_pkg::*;
  // ====================
  // message framing tracker
  logic first_ff;
  logic [PORT_W-1:0] port_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      first_ff <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      first_ff <= tx_last;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (tx_valid && tx_ready && first_ff) begin
      port_ff <= tx_port;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ====================
  // properties
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer to access");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_lmem_hold;
    lmem_req && !lmem_ack |=> lmem_req && $stable(lmem_addr) && $stable(lmem_we);
  endproperty
  a_lmem_hold: assert property (p_lmem_hold) else $error("memory request dropped");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("link word dropped");
  property p_tx_code;
    tx_valid && first_ff |-> (tx_data == TC_WRITE_WORD || tx_data == TC_READ_WORD) && !tx_last;
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("bad task code");
  property p_tx_port;
    tx_valid && !first_ff |-> tx_port == port_ff;
  endproperty
  a_tx_port: assert property (p_tx_port) else $error("port changed in message");
  property p_quiet;
    $fell(reset) |-> !tx_valid && !lmem_req && !pready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
endmodule

bind remote_xfer_cmd remote_xfer_cmd_asserts u_chk (
  .sys_clk, .reset, .psel, .penable, .prdata, .pready, .pslverr, .lmem_req, .lmem_we,
  .lmem_ack, .lmem_addr, .tx_valid, .tx_ready, .tx_data, .tx_port, .tx_last
);

// File: verification/tb_remote_xfer_cmd.sv
// self-checking bench for the remote transfer command block
`timescale 1ns/1ps
module tb_remote_xfer_cmd;
  import xfer_pkg::*;
  typedef struct {
    logic [15:0] code, conn, cnt, tmo, err;
    logic [1:0] mode, port;
  } row_t;
  localparam longint SEC = 400;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, lmem_ack = 0, sl;
  logic pready, pslverr, lmem_req, lmem_we, tx_valid, tx_ready, tx_last, rx_valid;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] lmem_addr, lmem_wdata, lmem_rdata = 0, tx_data, rx_code, rx_data;
  logic [1:0] tx_port, mode = 0;
  logic [15:0] lm [0:65535];
  int n_mismatch = 0, compares = 0, cyc = 0, t0;
  row_t rows [15];
  remote_xfer_cmd #(.SEC_CYCLES(SEC)) dut (.sys_clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .lmem_req, .lmem_we, .lmem_addr,
    .lmem_wdata, .lmem_ack, .lmem_rdata, .tx_valid, .tx_ready, .tx_data, .tx_port,
    .tx_last, .rx_valid, .rx_code, .rx_data);
  remote_plc_model u_rem (.sys_clk, .reset, .mode, .tx_valid, .tx_ready, .tx_data,
    .tx_port, .tx_last, .rx_valid, .rx_code, .rx_data);
  always #10 sys_clk = ~sys_clk;
  // ====================
  // local memory and watchdog
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      n_mismatch++;
      results();
    end
    lmem_ack <= lmem_req && !lmem_ack;
    lmem_rdata <= ~lmem_rdata;
    if (lmem_req && !lmem_ack) begin
      if (lmem_we) lm[lmem_addr] <= lmem_wdata;
      lmem_rdata <= lm[lmem_addr];
    end
  end
  // ====================
  // tasks
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic run(input row_t r);
    int n;
    mode <= r.mode;
    apb(1, 8'h00, 0);
    apb(1, 8'h04, r.code);
    apb(1, 8'h08, r.conn);
    apb(1, 8'h0C, 32'h0100);
    apb(1, 8'h10, r.cnt);
    apb(1, 8'h14, 32'h0200);
    apb(1, 8'h18, r.tmo);
    apb(1, REG_CTRL, 1);
    t0 = cyc;
    n = 0;
    do begin
      apb(0, REG_STATUS, 0);
      n++;
    end while (rd[1] !== 1'b1 && n < 3000);
    if (rd[1] !== 1'b1) begin
      n_mismatch++;
      results();
    end
    chk(rd[2:0], {r.err != 0, 2'h2});
    if (r.mode == 2'h2) chk((cyc - t0) / SEC, r.tmo == 0 ? 9 : r.tmo);
    apb(0, 8'h00, 0);
    chk(rd, r.err);
    if (r.err == 0) begin
      chk(u_rem.last_port, r.port);
      apb(0, REG_PROGRESS, 0);
      chk(rd, r.cnt);
      for (int k = 0; k < r.cnt; k++) begin
        if (r.code == CMD_WRITE_REMOTE) chk(u_rem.rm[16'h200 + k], lm[16'h100 + k]);
        else chk(lm[16'h200 + k], 16'h1100 + k);
      end
      if (r.code == CMD_WRITE_REMOTE) chk(u_rem.rm[16'h200 + r.cnt], 16'h1200 + r.cnt);
    end
  endtask
  // ====================
  // main sequence
  initial begin
    for (int i = 0; i < 65536; i++) lm[i] = 16'(i) ^ 16'hA5A5;
    rows = '{'{CMD_WRITE_REMOTE, 16'h4B01, 1, 0, 0, 0, 0},
      '{CMD_READ_REMOTE, 16'h4B02, 3, 0, 0, 3, 1}, '{CMD_WRITE_REMOTE, 16'h4B17, 2, 0, 0, 3, 2},
      '{CMD_READ_REMOTE, 16'h4B01, 256, 0, 0, 0, 0}, '{16'h0203, 16'h4B01, 1, 0, 1, 0, 0},
      '{CMD_WRITE_REMOTE, 16'h4B01, 0, 0, 2, 0, 0}, '{CMD_READ_REMOTE, 16'h4B01, 257, 0, 2, 0, 0},
      '{CMD_WRITE_REMOTE, 16'h4B05, 1, 0, 3, 0, 0}, '{CMD_WRITE_REMOTE, 16'h4B14, 1, 0, 3, 0, 0},
      '{CMD_WRITE_REMOTE, 16'h4B03, 1, 0, 4, 0, 0}, '{CMD_WRITE_REMOTE, 16'h4B16, 1, 0, 4, 0, 0},
      '{CMD_WRITE_REMOTE, 16'h4B01, 2, 0, 5, 1, 0}, '{CMD_READ_REMOTE, 16'h4B02, 1, 0, 5, 1, 0},
      '{CMD_WRITE_REMOTE, 16'h4B01, 1, 1, 6, 2, 0}, '{CMD_READ_REMOTE, 16'h4B01, 1, 0, 6, 2, 0}};
    do_reset();
    apb(0, REG_STATUS, 0);
    chk(rd, 0);
    apb(1, REG_PORT_RUN, 32'h43);
    apb(1, REG_CONN_BASE + 8'h08, 32'h4B17);
    foreach (rows[i]) run(rows[i]);
    apb(1, 8'h1C, 32'hFFFF);
    apb(0, 8'h1C, 0);
    chk(rd, 0);
    apb(0, 8'h60, 0);
    chk(sl, 1);
    mode <= 2'h2;
    apb(1, 8'h18, 32'h3E8);
    apb(1, REG_CTRL, 1);
    repeat (10 * SEC) @(posedge sys_clk);
    apb(1, REG_CTRL, 1);
    apb(0, REG_STATUS, 0);
    chk(rd, 1);
    do_reset();
    apb(0, REG_STATUS, 0);
    chk(rd, 0);
    results();
  end
endmodule
